// [core/epi_top.sv]
// Purpose: flags and enables for two external lines and three change groups
// Assumes: AHB-Lite single slave, core supplies global enable and acks
// Notes:   reads take one wait state, writes none
`timescale 1ns/10ps

// Contract
// - edge on line sets its flag bit
// - vector only with flag (low level in low mode), enable, global
// - core taking vector clears flag
// - write one clears flag, zero keeps
// - low-level mode holds flag at zero
// - unused upper flag/enable bits read zero
// - group two needs enable and global
// - group one needs enable and global
// - group zero needs enable and global
// - masked change sets group flag bit
// - group vector needs flag, enable, global
// - mask bit gates pin, with group enable
// - group-one mask bit seven reads zero
// - sense codes low, any, fall, rise
// - pins trigger even when driven out
// - change detect needs no peripheral clock
module epi_top import epi_pkg::*; (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic      [31:0]       hrdata,
  output logic                   hresp,
  input  wire logic              ext_line_a,
  input  wire logic              ext_line_b,
  input  wire logic [GRP0_W-1:0] change_inputs_low_group,
  input  wire logic [GRP1_W-1:0] change_inputs_mid_group,
  input  wire logic [GRP2_W-1:0] change_inputs_high_group,
  input  wire logic              global_irq_en,
  input  wire logic [4:0]        irq_ack,
  output logic      [4:0]        irq_req
);

  // ****************************************
  // declarations
  // ****************************************
  typedef enum logic [1:0] {
    EPI_BUS_IDLE = 2'b00,
    EPI_BUS_WR   = 2'b01,
    EPI_BUS_RDW  = 2'b10,
    EPI_BUS_RDD  = 2'b11
  } epi_bus_e;

  localparam int PIN_W = 2 + GRP0_W + GRP1_W + GRP2_W;

  epi_bus_e          state_q;
  logic [6:0]        idx_q;
  logic              take;
  logic [6:0]        idx_d;
  logic              wstb;
  logic [7:0]        wdat;
  logic [7:0]        rd_byte;
  logic [PIN_W-1:0]  pins_s;
  logic              line_a_s;
  logic              line_b_s;
  logic [7:0]        grp0_s;
  logic [6:0]        grp1_s;
  logic [7:0]        grp2_s;
  logic [7:0]        grp0_p_q;
  logic [6:0]        grp1_p_q;
  logic [7:0]        grp2_p_q;
  logic [7:0]        mask0_q;
  logic [6:0]        mask1_q;
  logic [7:0]        mask2_q;
  logic [2:0]        pc_en_q;
  logic [1:0]        ext_en_q;
  logic [3:0]        sense_q;
  logic [1:0]        ext_flag_q;
  logic [2:0]        pc_flag_q;
  logic [1:0]        trig;
  logic [1:0]        low_lvl;
  logic [1:0]        low_mode;
  logic [2:0]        pc_ev;
  logic [1:0]        ext_clr;
  logic [2:0]        pc_clr;
  epi_sense_e        sense_a;
  epi_sense_e        sense_b;

  // masked change in one group
  function automatic logic epi_chg(
    input logic [7:0] cur,
    input logic [7:0] prev,
    input logic [7:0] mask
  );
    epi_chg = |((cur ^ prev) & mask);
  endfunction : epi_chg

  // ****************************************
  // bus slave
  // ****************************************
  // address phase accept and decode
  assign take  = hsel && hready && htrans[1];
  assign idx_d = (haddr[31:9] == 23'h0 && haddr[1:0] == 2'b00 && hsize == HSIZE_WORD)
                 ? haddr[8:2] : IDX_NONE;
  assign wstb  = (state_q == EPI_BUS_WR);
  assign wdat  = hwdata[7:0];
  assign hreadyout = (state_q != EPI_BUS_RDW);
  assign hresp     = 1'b0;

  // transfer sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= EPI_BUS_IDLE;
      idx_q   <= IDX_NONE;
    end else begin
      unique case (state_q)
        EPI_BUS_RDW: state_q <= EPI_BUS_RDD;
        EPI_BUS_IDLE, EPI_BUS_WR, EPI_BUS_RDD: begin
          if (take) begin
            state_q <= hwrite ? EPI_BUS_WR : EPI_BUS_RDW;
            idx_q   <= idx_d;
          end else begin
            state_q <= EPI_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // read mux, unused bits zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx_q)
      IDX_MASK0:     rd_byte = mask0_q;
      IDX_MASK1:     rd_byte = {1'b0, mask1_q};
      IDX_MASK2:     rd_byte = mask2_q;
      IDX_PC_FLAGS:  rd_byte = {5'h00, pc_flag_q};
      IDX_EXT_FLAGS: rd_byte = {6'h00, ext_flag_q & ~low_mode};
      IDX_EXT_EN:    rd_byte = {6'h00, ext_en_q};
      IDX_PC_EN:     rd_byte = {5'h00, pc_en_q};
      IDX_SENSE:     rd_byte = {4'h0, sense_q};
      default:       rd_byte = 8'h00;
    endcase
  end

  // read data captured in wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (state_q == EPI_BUS_RDW) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // masks, enables, sense codes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask0_q  <= RST_BYTE;
      mask1_q  <= RST_BYTE[6:0];
      mask2_q  <= RST_BYTE;
      pc_en_q  <= RST_BYTE[2:0];
      ext_en_q <= RST_BYTE[1:0];
      sense_q  <= RST_BYTE[3:0];
    end else if (wstb) begin
      if (idx_q == IDX_MASK0) mask0_q <= wdat;
      if (idx_q == IDX_MASK1) mask1_q <= wdat[6:0];
      if (idx_q == IDX_MASK2) mask2_q <= wdat;
      if (idx_q == IDX_PC_EN) pc_en_q <= wdat[2:0];
      if (idx_q == IDX_EXT_EN) ext_en_q <= wdat[1:0];
      if (idx_q == IDX_SENSE) sense_q <= wdat[3:0];
    end
  end

  assign sense_a = epi_sense_e'(sense_q[SENSE_A_LO +: 2]);
  assign sense_b = epi_sense_e'(sense_q[SENSE_B_LO +: 2]);
  assign low_mode = {sense_b == EPI_SENSE_LOW, sense_a == EPI_SENSE_LOW};

  // ****************************************
  // pin capture and detection
  // ****************************************
  // pins sampled whatever their port direction
  epi_sync #(
    .W (PIN_W)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({ext_line_b, ext_line_a, change_inputs_high_group,
                change_inputs_mid_group, change_inputs_low_group}),
    .q       (pins_s)
  );

  assign {line_b_s, line_a_s, grp2_s, grp1_s, grp0_s} = pins_s;

  // sense per line
  epi_sense u_sense_a (
    .hclk    (hclk),
    .hresetn (hresetn),
    .line_s  (line_a_s),
    .mode    (sense_a),
    .trig    (trig[BIT_LINE_A]),
    .low_lvl (low_lvl[BIT_LINE_A])
  );

  epi_sense u_sense_b (
    .hclk    (hclk),
    .hresetn (hresetn),
    .line_s  (line_b_s),
    .mode    (sense_b),
    .trig    (trig[BIT_LINE_B]),
    .low_lvl (low_lvl[BIT_LINE_B])
  );

  // previous group levels, system clock only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grp0_p_q <= 8'h00;
      grp1_p_q <= 7'h00;
      grp2_p_q <= 8'h00;
    end else begin
      grp0_p_q <= grp0_s;
      grp1_p_q <= grp1_s;
      grp2_p_q <= grp2_s;
    end
  end

  // masked change, gated by group enable
  assign pc_ev[BIT_GRP0] = pc_en_q[BIT_GRP0] && epi_chg(grp0_s, grp0_p_q, mask0_q);
  assign pc_ev[BIT_GRP1] = pc_en_q[BIT_GRP1] &&
                           epi_chg({1'b0, grp1_s}, {1'b0, grp1_p_q}, {1'b0, mask1_q});
  assign pc_ev[BIT_GRP2] = pc_en_q[BIT_GRP2] && epi_chg(grp2_s, grp2_p_q, mask2_q);

  // ****************************************
  // flags
  // ****************************************
  // clear by write-one or by core ack
  assign ext_clr = ({2{wstb && idx_q == IDX_EXT_FLAGS}} & wdat[1:0])
                 | irq_ack[REQ_LINE_B:REQ_LINE_A];
  assign pc_clr  = ({3{wstb && idx_q == IDX_PC_FLAGS}} & wdat[2:0])
                 | irq_ack[REQ_GRP2:REQ_GRP0];

  // external flags, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_flag_q <= 2'b00;
    end else begin
      ext_flag_q <= ~low_mode & (trig | (ext_flag_q & ~ext_clr));
    end
  end

  // group flags, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_flag_q <= 3'b000;
    end else begin
      pc_flag_q <= pc_ev | (pc_flag_q & ~pc_clr);
    end
  end

  // ****************************************
  // requests to the core
  // ****************************************
  // flag (low level in low mode) and enable and global bit
  always_comb begin
    irq_req[REQ_LINE_A] = global_irq_en && ext_en_q[BIT_LINE_A] &&
      (low_mode[BIT_LINE_A] ? low_lvl[BIT_LINE_A] : ext_flag_q[BIT_LINE_A]);
    irq_req[REQ_LINE_B] = global_irq_en && ext_en_q[BIT_LINE_B] &&
      (low_mode[BIT_LINE_B] ? low_lvl[BIT_LINE_B] : ext_flag_q[BIT_LINE_B]);
    irq_req[REQ_GRP0] = global_irq_en && pc_en_q[BIT_GRP0] && pc_flag_q[BIT_GRP0];
    irq_req[REQ_GRP1] = global_irq_en && pc_en_q[BIT_GRP1] && pc_flag_q[BIT_GRP1];
    irq_req[REQ_GRP2] = global_irq_en && pc_en_q[BIT_GRP2] && pc_flag_q[BIT_GRP2];
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rise_a;
    sense_a == EPI_SENSE_RISE && !line_a_s ##1 sense_a == EPI_SENSE_RISE && line_a_s;
  endsequence

  sequence s_rd_take;
    take && !hwrite;
  endsequence

  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  // no request without global bit
  a_req_global: assert property (
    irq_req != 5'h00 |-> global_irq_en
  ) else $error("request without global enable");

  // rising edge sets line flag
  a_rise_sets: assert property (
    s_rise_a |=> ext_flag_q[BIT_LINE_A]
  ) else $error("rising edge did not set flag");

  // ack clears flag when no new event
  a_ack_clear: assert property (
    irq_ack[REQ_GRP1] && !pc_ev[BIT_GRP1] |=> !pc_flag_q[BIT_GRP1]
  ) else $error("ack did not clear flag");

  // write one clears external flag
  a_w1c_clear: assert property (
    wstb && idx_q == IDX_EXT_FLAGS && wdat[BIT_LINE_B] && !trig[BIT_LINE_B]
    |=> !ext_flag_q[BIT_LINE_B]
  ) else $error("write one did not clear flag");

  // write zero keeps group flags
  a_w0_keeps: assert property (
    wstb && idx_q == IDX_PC_FLAGS && wdat[2:0] == 3'h0 && irq_ack[4:2] == 3'h0
    |=> (pc_flag_q & $past(pc_flag_q)) == $past(pc_flag_q)
  ) else $error("write zero changed a flag");

  // low mode keeps flag zero
  a_low_hold: assert property (
    (sense_b == EPI_SENSE_LOW) [*2] |-> ext_flag_q[BIT_LINE_B] == 1'b0
  ) else $error("flag set in low-level mode");

  // masked change sets group flag
  a_pc_set: assert property (
    pc_ev[BIT_GRP2] |=> pc_flag_q[BIT_GRP2]
  ) else $error("group flag not set on change");

  // group zero request one cycle after change
  a_grp0_req: assert property (
    global_irq_en && pc_en_q[BIT_GRP0] && ((grp0_s ^ grp0_p_q) & mask0_q) != 8'h00
    ##1 global_irq_en && pc_en_q[BIT_GRP0] |-> irq_req[REQ_GRP0]
  ) else $error("group zero request missing");

  // disabled group one or two never requests
  a_grp_gate: assert property (
    (irq_req[REQ_GRP2:REQ_GRP1] & ~pc_en_q[BIT_GRP2:BIT_GRP1]) == 2'b00
  ) else $error("group request while disabled");

  // group-one mask top bit reads zero
  a_mask1_top: assert property (
    state_q == EPI_BUS_RDD && idx_q == IDX_MASK1 |-> hrdata[31:7] == 25'h0
  ) else $error("mask one top bit not zero");

  // flag register upper bits zero
  a_flags_upper: assert property (
    state_q == EPI_BUS_RDD && idx_q == IDX_EXT_FLAGS |-> hrdata[31:2] == 30'h0
  ) else $error("flag upper bits not zero");

  // read answers after one wait
  a_read_wait: assert property (
    s_rd_take |=> s_rd_answer
  ) else $error("read wait state wrong");

endmodule : epi_top

// [inc/epi_pkg.sv]
// Purpose: shared constants for the external and pin-change interrupt flags
// Assumes: word-per-register bus map, byte address is four times the index
// Notes:   reserved bits read as zero everywhere
package epi_pkg;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [6:0] IDX_MASK0     = 7'h6b;
  localparam logic [6:0] IDX_MASK1     = 7'h6c;
  localparam logic [6:0] IDX_MASK2     = 7'h6d;
  localparam logic [6:0] IDX_PC_FLAGS  = 7'h1b;
  localparam logic [6:0] IDX_EXT_FLAGS = 7'h1c;
  localparam logic [6:0] IDX_EXT_EN    = 7'h1d;
  localparam logic [6:0] IDX_PC_EN     = 7'h68;
  localparam logic [6:0] IDX_SENSE     = 7'h69;
  localparam logic [6:0] IDX_NONE      = 7'h00;

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam int         BIT_LINE_A = 0;
  localparam int         BIT_LINE_B = 1;
  localparam int         BIT_GRP0   = 0;
  localparam int         BIT_GRP1   = 1;
  localparam int         BIT_GRP2   = 2;
  localparam int         SENSE_A_LO = 0;
  localparam int         SENSE_B_LO = 2;
  localparam int         REQ_LINE_A = 0;
  localparam int         REQ_LINE_B = 1;
  localparam int         REQ_GRP0   = 2;
  localparam int         REQ_GRP1   = 3;
  localparam int         REQ_GRP2   = 4;
  localparam int         GRP0_W     = 8;
  localparam int         GRP1_W     = 7;
  localparam int         GRP2_W     = 8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    EPI_SENSE_LOW  = 2'b00,
    EPI_SENSE_ANY  = 2'b01,
    EPI_SENSE_FALL = 2'b10,
    EPI_SENSE_RISE = 2'b11
  } epi_sense_e;

endpackage : epi_pkg

// [core/epi_sync.sv]
// Purpose: two-stage synchroniser for a bundle of pin levels
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module epi_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;

  // two flops per bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      q    <= s1_q;
    end
  end

endmodule : epi_sync

// [core/epi_sense.sv]
// Purpose: edge and level sense for one external line
// Assumes: line already synchronised to hclk
// Notes:   low mode gives no event, only a level
`timescale 1ns/10ps
module epi_sense import epi_pkg::*; (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       line_s,
  input  wire epi_sense_e mode,
  output logic            trig,
  output logic            low_lvl
);

  logic prev_q;

  // previous level for edge compare
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= line_s;
    end
  end

  // event by sense code
  always_comb begin
    unique case (mode)
      EPI_SENSE_LOW:  trig = 1'b0;
      EPI_SENSE_ANY:  trig = line_s ^ prev_q;
      EPI_SENSE_FALL: trig = prev_q & ~line_s;
      EPI_SENSE_RISE: trig = ~prev_q & line_s;
    endcase
  end

  assign low_lvl = (mode == EPI_SENSE_LOW) && !line_s;

endmodule : epi_sense

// [tb/epi_core_model.sv]
// Purpose: core side that takes a requested vector and acknowledges it
// Assumes: acks the lowest pending request after ack_dly idle cycles
// Notes:   one-cycle ack pulse, never while a previous ack is out
`timescale 1ns/10ps
module epi_core_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       core_en,
  input  wire logic [3:0] ack_dly,
  input  wire logic [4:0] irq_req,
  output logic      [4:0] irq_ack
);
  // ****************************************
  // vector take and acknowledge
  // ****************************************
  logic [3:0] cnt_q;

  // wait, then pulse the ack of the lowest requesting vector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q   <= 4'h0;
      irq_ack <= 5'h00;
    end else begin
      irq_ack <= 5'h00;
      if (core_en && (irq_req != 5'h00) && (irq_ack == 5'h00)) begin
        if (cnt_q == ack_dly) begin
          irq_ack <= irq_req & (~irq_req + 5'h01);
          cnt_q   <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end else begin
        cnt_q <= 4'h0;
      end
    end
  end
endmodule : epi_core_model

// [tb/ext_and_pin_change_irq_flags_bench.sv]
// Purpose: self-checking bench for the interrupt flag block
// Assumes: single AHB-Lite master, hready looped from hreadyout
// Notes:   register table in rows, pin and ack cases by hand
`timescale 1ns/10ps
module ext_and_pin_change_irq_flags_bench import epi_pkg::*;;
  typedef struct packed {logic [6:0] idx; logic [7:0] wd; logic [7:0] ex;} epi_row_s;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, global_irq_en = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize  = HSIZE_WORD;
  logic hreadyout, hresp, ext_line_a = 1'b1, ext_line_b = 1'b1, core_en = 1'b0;
  logic [7:0] lo = 8'h00, hi = 8'h00, v;
  logic [6:0] mid = 7'h00;
  logic [4:0] irq_ack, irq_req;
  logic [3:0] ack_dly = 4'h0;
  int n_mismatch = 0, total_checks = 0;
  epi_row_s rows [9] = '{'{IDX_MASK0, 8'hff, 8'hff}, '{IDX_MASK1, 8'hff, 8'h7f},
    '{IDX_MASK2, 8'ha5, 8'ha5}, '{IDX_PC_EN, 8'hff, 8'h07}, '{IDX_EXT_EN, 8'hff, 8'h03},
    '{IDX_SENSE, 8'h0f, 8'h0f}, '{IDX_EXT_FLAGS, 8'hff, 8'h00},
    '{IDX_PC_FLAGS, 8'hff, 8'h00}, '{IDX_NONE, 8'hff, 8'h00}};
  logic [7:0] fall_ex [4] = '{8'h00, 8'h03, 8'h03, 8'h00};
  logic [7:0] rise_ex [4] = '{8'h00, 8'h03, 8'h00, 8'h03};

  // clock and design under test
  always #5 hclk = ~hclk;
  epi_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_line_a(ext_line_a),
    .ext_line_b(ext_line_b), .change_inputs_low_group(lo), .change_inputs_mid_group(mid),
    .change_inputs_high_group(hi), .global_irq_en(global_irq_en), .irq_ack(irq_ack),
    .irq_req(irq_req));
  epi_core_model i_core (.hclk(hclk), .hresetn(hresetn), .core_en(core_en),
    .ack_dly(ack_dly), .irq_req(irq_req), .irq_ack(irq_ack));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] ex);
    total_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, ex);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    logic [31:0] d;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {23'h0, idx, 2'b00};
    wait_rdy(d);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_rdy(d);
    rd = d[7:0];
  endtask : bus
  task automatic wr(input logic [6:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd, v);
  endtask : wr
  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] ex);
    bus(1'b0, idx, 8'h00, v);
    chk(v, ex);
  endtask : rd_chk
  task automatic req_chk(input logic [7:0] ex);
    @(negedge hclk);
    chk({3'h0, irq_req}, ex);
    @(posedge hclk);
  endtask : req_chk
  task automatic lines(input logic l);
    @(posedge hclk);
    ext_line_a <= l;
    ext_line_b <= l;
    cyc(6);
  endtask : lines
  task automatic pins(input logic [7:0] l, input logic [6:0] m, input logic [7:0] h);
    @(posedge hclk);
    lo  <= lo ^ l;
    mid <= mid ^ m;
    hi  <= hi ^ h;
    cyc(6);
  endtask : pins
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // watchdog against a hung handshake
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    cyc(10);
    hresetn <= 1'b1;
    foreach (rows[i]) rd_chk(rows[i].idx, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rd_chk(rows[i].idx, rows[i].ex);
    end
    // byte-size access is unmapped: write ignored, answer okay
    hsize <= 3'h0;
    wr(IDX_MASK0, 8'h00);
    hsize <= HSIZE_WORD;
    rd_chk(IDX_MASK0, 8'hff);
    chk({7'h00, hresp}, 8'h00);
    // external lines in every sense code
    global_irq_en <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(IDX_SENSE, {4'h0, m[1:0], m[1:0]});
      wr(IDX_EXT_FLAGS, 8'h03);
      lines(1'b0);
      rd_chk(IDX_EXT_FLAGS, fall_ex[m]);
      if (m == 0) req_chk(8'h03);
      wr(IDX_EXT_FLAGS, 8'h03);
      lines(1'b1);
      rd_chk(IDX_EXT_FLAGS, rise_ex[m]);
    end
    req_chk(8'h03);
    global_irq_en <= 1'b0;
    req_chk(8'h00);
    global_irq_en <= 1'b1;
    wr(IDX_EXT_EN, 8'h01);
    req_chk(8'h01);
    wr(IDX_EXT_FLAGS, 8'h01);
    rd_chk(IDX_EXT_FLAGS, 8'h02);
    wr(IDX_EXT_EN, 8'h02);
    ack_dly <= 4'h5;
    core_en <= 1'b1;
    cyc(12);
    rd_chk(IDX_EXT_FLAGS, 8'h00);
    core_en <= 1'b0;
    // change groups: masked pins first, then one live pin per group
    wr(IDX_MASK0, 8'h01);
    wr(IDX_MASK1, 8'h40);
    wr(IDX_MASK2, 8'h80);
    wr(IDX_PC_EN, 8'h07);
    pins(8'h02, 7'h01, 8'h01);
    rd_chk(IDX_PC_FLAGS, 8'h00);
    pins(8'h01, 7'h00, 8'h00);
    rd_chk(IDX_PC_FLAGS, 8'h01);
    pins(8'h00, 7'h40, 8'h00);
    rd_chk(IDX_PC_FLAGS, 8'h03);
    pins(8'h00, 7'h00, 8'h80);
    rd_chk(IDX_PC_FLAGS, 8'h07);
    wr(IDX_PC_FLAGS, 8'h00);
    rd_chk(IDX_PC_FLAGS, 8'h07);
    req_chk(8'h1c);
    global_irq_en <= 1'b0;
    req_chk(8'h00);
    global_irq_en <= 1'b1;
    wr(IDX_PC_EN, 8'h00);
    req_chk(8'h00);
    wr(IDX_PC_FLAGS, 8'h07);
    pins(8'h01, 7'h40, 8'h80);
    rd_chk(IDX_PC_FLAGS, 8'h00);
    wr(IDX_PC_EN, 8'h07);
    pins(8'h01, 7'h40, 8'h80);
    ack_dly <= 4'h0;
    core_en <= 1'b1;
    cyc(10);
    rd_chk(IDX_PC_FLAGS, 8'h00);
    // reset in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    rd_chk(IDX_PC_EN, 8'h00);
    rd_chk(IDX_MASK1, 8'h00);
    print_verdict();
  end
endmodule : ext_and_pin_change_irq_flags_bench
